// >>> bus_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bus_sync #(
  parameter int W = 19
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // First stage takes the pins, second stage only the first
  always_comb begin
    s_d.meta = async_in;
    s_d.held = s_q.meta;
  end

  // Two-stage synchroniser for pin inputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Only the settled stage leaves the block
  assign sync_out = s_q.held;

endmodule // bus_sync

`default_nettype wire

// >>> channel_request_prioritizer.sv
`timescale 1ns/1ps
`default_nettype none

module channel_request_prioritizer
  import hub_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic mode_dma,
  input wire logic eight_chan,
  input wire logic low_bank,
  input wire logic [7:0] data_req,
  input wire logic [7:0] block_end_request,
  input wire logic host_ack,
  input wire logic dma_ack,
  input wire logic diag_start,
  input wire logic [2:0] diag_chan,
  input wire logic pio_branch,
  input wire logic pio_xfer,
  input wire logic [2:0] pio_chan,
  output logic host_irq,
  output logic [7:0] host_vector,
  output logic dma_req,
  output logic [2:0] dma_chan,
  output logic diag_fail,
  output logic [7:0] loop_test,
  output logic [7:0] branch_cmd,
  output logic [7:0] pio_sel,
  output logic sys_clk
);

  typedef struct packed {
    state_e st;
    logic irq;
    logic [7:0] vec;
    logic dreq;
    logic [2:0] dch;
    logic [2:0] dgch;
    logic dg_ok;
    logic dg_fail;
    logic [5:0] cnt;
    logic [1:0] div;
    logic sclk;
    logic [7:0] br;
    logic [7:0] pio;
    logic [7:0] loop;
  } hub_s;

  hub_s s_q;
  hub_s s_d;
  logic [18:0] pins_s;
  logic m_dma;
  logic m_eight;
  logic m_low;
  logic [7:0] dreq_s;
  logic [7:0] breq_s;
  logic [7:0] act;
  logic [7:0] dreq_m;
  logic [7:0] breq_m;
  logic d_any;
  logic b_any;
  logic [2:0] d_idx;
  logic [2:0] b_idx;

  // Channel group enabled for the chosen variant
  function automatic logic [7:0] active_mask(input logic dma, input logic eight, input logic low);
    logic [7:0] m;
    if (dma) begin
      m = low ? MASK_LOW : MASK_HIGH;
    end else begin
      m = eight ? MASK_ALL : MASK_HIGH;
    end
    return m;
  endfunction

  // Vector: base, request type, channel
  function automatic logic [7:0] make_vec(input logic is_end, input logic [2:0] ch);
    return {VEC_BASE_HI, is_end, ch};
  endfunction

  // Pins from the adapters and straps
  bus_sync #(.W(19)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({mode_dma, eight_chan, low_bank, data_req, block_end_request}),
    .sync_out(pins_s)
  );

  assign m_dma = pins_s[18];
  assign m_eight = pins_s[17];
  assign m_low = pins_s[16];
  assign dreq_s = pins_s[15:8];
  assign breq_s = pins_s[7:0];
  assign act = active_mask(m_dma, m_eight, m_low);
  assign dreq_m = dreq_s & act;
  assign breq_m = breq_s & act;

  // Ranking of each request class
  prio_pick u_pick_data (
    .req(dreq_m),
    .any(d_any),
    .idx(d_idx)
  );

  prio_pick u_pick_end (
    .req(breq_m),
    .any(b_any),
    .idx(b_idx)
  );

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.br = 8'h00;
    s_d.pio = 8'h00;
    // System clock divider
    if (s_q.div == SYS_DIV_LAST) begin
      s_d.div = 2'h0;
    end else begin
      s_d.div = s_q.div + 2'h1;
    end
    s_d.sclk = (s_d.div == 2'h0);
    // Program-control commands, any state
    if (pio_branch && act[pio_chan]) begin
      s_d.br[pio_chan] = 1'b1;
    end
    if (pio_xfer && act[pio_chan]) begin
      s_d.pio[pio_chan] = 1'b1;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (m_dma && d_any) begin
          s_d.st = ST_DMA;
          s_d.dreq = 1'b1;
          s_d.dch = d_idx;
        end else if (m_dma && s_q.dg_ok) begin
          s_d.st = ST_IRQ;
          s_d.irq = 1'b1;
          s_d.vec = make_vec(1'b1, s_q.dgch);
        end else if (m_dma && diag_start && act[diag_chan]) begin
          s_d.st = ST_DIAG;
          s_d.dgch = diag_chan;
          s_d.loop = 8'h01 << diag_chan;
          s_d.cnt = 6'h00;
          s_d.dg_fail = 1'b0;
        end else if (!m_dma && d_any) begin
          s_d.st = ST_IRQ;
          s_d.irq = 1'b1;
          s_d.vec = make_vec(1'b0, d_idx);
        end else if (b_any) begin
          s_d.st = ST_IRQ;
          s_d.irq = 1'b1;
          s_d.vec = make_vec(1'b1, b_idx);
        end
      end
      ST_IRQ: begin
        if (host_ack) begin
          s_d.irq = 1'b0;
          s_d.st = ST_GUARD;
          s_d.cnt = 6'h00;
          if (s_q.dg_ok && s_q.vec[3] && s_q.vec[2:0] == s_q.dgch) begin
            s_d.dg_ok = 1'b0;
          end
        end else if (m_dma && d_any) begin
          s_d.irq = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      ST_DMA: begin
        if (dma_ack) begin
          s_d.dreq = 1'b0;
          s_d.st = ST_GUARD;
          s_d.cnt = 6'h00;
        end
      end
      ST_DIAG: begin
        if (dreq_s[s_q.dgch]) begin
          s_d.loop = 8'h00;
          s_d.dg_ok = 1'b1;
          s_d.st = ST_GUARD;
          s_d.cnt = 6'h00;
        end else if (s_q.cnt == DIAG_LAST) begin
          s_d.loop = 8'h00;
          s_d.dg_fail = 1'b1;
          s_d.st = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 6'h01;
        end
      end
      ST_GUARD: begin
        if (s_q.cnt == GUARD_LAST) begin
          s_d.st = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 6'h01;
        end
      end
      default: begin
        s_d = '0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state
  assign host_irq = s_q.irq;
  assign host_vector = s_q.vec;
  assign dma_req = s_q.dreq;
  assign dma_chan = s_q.dch;
  assign diag_fail = s_q.dg_fail;
  assign loop_test = s_q.loop;
  assign branch_cmd = s_q.br;
  assign pio_sel = s_q.pio;
  assign sys_clk = s_q.sclk;

  // Checks on the block's own behaviour
  a_vec_stable: assert property (@(posedge clock) disable iff (!rstn)
    host_irq && !host_ack && !(m_dma && d_any) |=> host_irq && $stable(host_vector))
    else $error("vector changed while interrupt pending");

  a_ack_drop: assert property (@(posedge clock) disable iff (!rstn)
    host_irq && host_ack |=> !host_irq [*3])
    else $error("interrupt not withdrawn after acknowledge");

  a_dma_yield: assert property (@(posedge clock) disable iff (!rstn)
    host_irq && !host_ack && m_dma && d_any |=> !host_irq)
    else $error("block-end interrupt held over data request");

  a_dma_grant: assert property (@(posedge clock) disable iff (!rstn)
    s_q.st == ST_IDLE && m_dma && d_any |=> dma_req && dma_chan == $past(d_idx))
    else $error("data request not granted in order");

  a_dma_hold: assert property (@(posedge clock) disable iff (!rstn)
    dma_req && !dma_ack |=> dma_req && $stable(dma_chan) && !host_irq)
    else $error("transfer request dropped early");

  a_dma_group: assert property (@(posedge clock) disable iff (!rstn)
    $rose(dma_req) |-> (dma_chan[2] == !m_low))
    else $error("transfer on channel outside group");

  a_sys_period: assert property (@(posedge clock) disable iff (!rstn)
    $rose(sys_clk) |=> !sys_clk ##1 !sys_clk ##1 sys_clk)
    else $error("system clock period wrong");

  a_branch_one: assert property (@(posedge clock) disable iff (!rstn)
    $onehot0(branch_cmd) && (branch_cmd == 8'h00 || $past(pio_branch)))
    else $error("branch command without host request");

  a_loop_diag: assert property (@(posedge clock) disable iff (!rstn)
    loop_test != 8'h00 |-> s_q.st == ST_DIAG && loop_test[s_q.dgch])
    else $error("loop drive outside diagnostic");

  a_diag_end: assert property (@(posedge clock) disable iff (!rstn)
    $rose(s_q.st == ST_DIAG) |-> ##[1:40] s_q.st != ST_DIAG)
    else $error("diagnostic did not end in time");

  a_small_map: assert property (@(posedge clock) disable iff (!rstn)
    $rose(host_irq) && !m_dma && !m_eight |-> host_vector[2])
    else $error("four-channel hub served low channel");

  a_pio_one: assert property (@(posedge clock) disable iff (!rstn)
    $onehot0(pio_sel) && (pio_sel == 8'h00 || $past(pio_xfer)))
    else $error("transfer select without host request");

  a_irq_order: assert property (@(posedge clock) disable iff (!rstn)
    s_q.st == ST_IDLE && !m_dma && d_any |=> host_irq && host_vector[3:0] == {1'b0, $past(d_idx)})
    else $error("interrupt not raised for first data request");

  a_diag_timeout: assert property (@(posedge clock) disable iff (!rstn)
    s_q.st == ST_DIAG && s_q.cnt == DIAG_LAST && !dreq_s[s_q.dgch] |=> diag_fail && loop_test == 8'h00)
    else $error("diagnostic timeout not reported");

  c_irq_served: cover property (@(posedge clock) disable iff (!rstn)
    host_irq ##1 host_ack);
  c_dma_done: cover property (@(posedge clock) disable iff (!rstn)
    dma_req && dma_ack);
  c_diag_pass: cover property (@(posedge clock) disable iff (!rstn)
    $fell(s_q.dg_ok));
  c_diag_fail: cover property (@(posedge clock) disable iff (!rstn)
    $rose(diag_fail));

endmodule // channel_request_prioritizer

`default_nettype wire

// >>> host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] dly,
  input wire logic host_irq,
  input wire logic [7:0] host_vector,
  input wire logic dma_req,
  input wire logic [2:0] dma_chan,
  output logic host_ack,
  output logic dma_ack,
  output logic [8:0] last_ev,
  output logic [15:0] n_ev
);
  logic [3:0] wait_q;

  // Answers after dly cycles, one-cycle pulse; logs what was served
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 4'h0;
      host_ack <= 1'b0;
      dma_ack <= 1'b0;
      last_ev <= 9'h000;
      n_ev <= 16'h0000;
    end else if (host_ack || dma_ack) begin
      if (host_ack && host_irq) begin
        last_ev <= {1'b0, host_vector};
        n_ev <= n_ev + 16'h0001;
      end
      if (dma_ack && dma_req) begin
        last_ev <= {6'h20, dma_chan};
        n_ev <= n_ev + 16'h0001;
      end
      host_ack <= 1'b0;
      dma_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if ((host_irq || dma_req) && wait_q >= dly) begin
      host_ack <= host_irq && !dma_req;
      dma_ack <= dma_req;
    end else if (host_irq || dma_req) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // host_model

`default_nettype wire

// >>> hub_pkg.sv
package hub_pkg;

  // Channel count and vector layout
  localparam int NCH = 8;
  localparam logic [3:0] VEC_BASE_HI = 4'h4; // Arbitrary vector base

  // Channel groups for each hub variant
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_HIGH = 8'hf0;
  localparam logic [7:0] MASK_LOW = 8'h0f;

  // Core clock and shared system clock
  localparam int CLK_NS = 100;
  localparam int SYS_CLK_NS = 250;
  localparam int SYS_DIV_CYC = (SYS_CLK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] SYS_DIV_LAST = 2'(SYS_DIV_CYC - 1);

  // Loop diagnostic answer window
  localparam int DIAG_WAIT_NS = 3200;
  localparam int DIAG_CYC = DIAG_WAIT_NS / CLK_NS;
  localparam logic [5:0] DIAG_LAST = 6'(DIAG_CYC - 1);

  // Hold-off after service, covers the input synchroniser depth
  localparam int GUARD_CYC = 3;
  localparam logic [5:0] GUARD_LAST = 6'(GUARD_CYC - 1);

  typedef enum logic [2:0] {ST_IDLE, ST_IRQ, ST_DMA, ST_DIAG, ST_GUARD} state_e;

endpackage

// >>> prio_pick.sv
`timescale 1ns/1ps
`default_nettype none

module prio_pick (
  input wire logic [7:0] req,
  output logic any,
  output logic [2:0] idx
);

  // Fixed order: lowest channel number wins
  always_comb begin
    any = |req;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
  end

endmodule // prio_pick

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
  import hub_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic mode_dma, eight_chan, low_bank, host_ack, dma_ack, diag_start, pio_branch, pio_xfer;
  logic host_irq, dma_req, diag_fail, sys_clk;
  logic [7:0] data_req, block_end_request, host_vector, loop_test, branch_cmd, pio_sel, m;
  logic [2:0] diag_chan, pio_chan, dma_chan;
  logic [3:0] dly;
  logic [8:0] last_ev, cnt;
  logic [15:0] n_ev;
  int fails = 0;
  int n_checks = 0;
  int unsigned seed_v;

  channel_request_prioritizer DUT (.clock, .rstn, .mode_dma, .eight_chan, .low_bank, .data_req,
    .block_end_request, .host_ack, .dma_ack, .diag_start, .diag_chan, .pio_branch, .pio_xfer,
    .pio_chan, .host_irq, .host_vector, .dma_req, .dma_chan, .diag_fail, .loop_test, .branch_cmd,
    .pio_sel, .sys_clk);
  host_model host (.clock, .rstn, .dly, .host_irq, .host_vector, .dma_req, .dma_chan, .host_ack,
    .dma_ack, .last_ev, .n_ev);

  // Clock
  always #(CLK_NS / 2) clock = ~clock;

  // Compare and count, print on mismatch
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Step n edges, then settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Wait for the host to log a new event, bounded
  task automatic wait_ev(input logic [15:0] k);
    for (int t = 0; t < 300 && n_ev == k; t++) cyc(1);
  endtask

  // Next served event: data first, lowest channel first
  function automatic logic [8:0] expect_ev(input logic [7:0] dr, input logic [7:0] be);
    for (int i = 0; i < NCH; i++) if (dr[i]) return mode_dma ? {6'h20, 3'(i)} : {1'b0, VEC_BASE_HI, 1'b0, 3'(i)};
    for (int i = 0; i < NCH; i++) if (be[i]) return {1'b0, VEC_BASE_HI, 1'b1, 3'(i)};
    return 9'h000;
  endfunction

  // Random requests in the current mode, served one by one
  task automatic round();
    logic [7:0] dr;
    logic [7:0] be;
    logic [8:0] e;
    logic [15:0] k;
    dr = 8'($urandom) & (mode_dma ? m : 8'hff);
    be = 8'($urandom) & (mode_dma ? m : 8'hff);
    dly = 4'($urandom_range(0, 5));
    data_req = dr;
    block_end_request = be;
    dr &= m;
    be &= m;
    while ((dr | be) != 8'h00) begin
      k = n_ev;
      wait_ev(k);
      e = expect_ev(dr, be);
      check(last_ev, e);
      if (e[8] || !e[3]) begin
        dr[e[2:0]] = 1'b0;
        data_req[e[2:0]] = 1'b0;
      end else begin
        be[e[2:0]] = 1'b0;
        block_end_request[e[2:0]] = 1'b0;
      end
    end
    k = n_ev;
    cyc(12);
    check(9'(n_ev), 9'(k));
    data_req = 8'h00;
    block_end_request = 8'h00;
    cyc(6);
  endtask

  // Loop diagnostic: timeout first, then a passing loop
  task automatic diag();
    logic [2:0] c;
    logic [15:0] k;
    c = {!low_bank, 2'($urandom)};
    diag_chan = c;
    diag_start = 1'b1;
    cyc(1);
    diag_start = 1'b0;
    check(9'(loop_test), 9'(8'h01 << c));
    cyc(DIAG_CYC - 1);
    check(9'(loop_test), 9'(8'h01 << c));
    cyc(1);
    check({diag_fail, loop_test}, 9'h100);
    k = n_ev;
    diag_start = 1'b1;
    cyc(1);
    diag_start = 1'b0;
    check({diag_fail, loop_test}, {1'b0, 8'h01 << c});
    cyc(3);
    data_req[c] = 1'b1;
    for (int t = 0; t < 20 && loop_test !== 8'h00; t++) cyc(1);
    data_req[c] = 1'b0;
    wait_ev(k);
    check(last_ev, {1'b0, VEC_BASE_HI, 1'b1, c});
  endtask

  // Block-end interrupt must give way to a late data request
  task automatic yield_case();
    logic [2:0] c;
    logic [15:0] k;
    c = {!low_bank, 2'($urandom)};
    dly = 4'hf;
    block_end_request[c] = 1'b1;
    for (int t = 0; t < 20 && host_irq !== 1'b1; t++) cyc(1);
    k = n_ev;
    data_req[c] = 1'b1;
    wait_ev(k);
    check(last_ev, {6'h20, c});
    data_req[c] = 1'b0;
    k = n_ev;
    wait_ev(k);
    check(last_ev, {1'b0, VEC_BASE_HI, 1'b1, c});
    block_end_request[c] = 1'b0;
    cyc(6);
  endtask

  // Counts and verdict, end of run
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(CLK_NS * 30000);
    fails++;
    summarize();
  end

  // Main sequence
  initial begin
    {mode_dma, eight_chan, low_bank, diag_start, pio_branch, pio_xfer} = 6'h00;
    {data_req, block_end_request} = 16'h0000;
    {diag_chan, pio_chan, dly, m} = 18'h00000;
    seed_v = $urandom(32'h78dc);
    repeat (2) @(posedge clock);
    #1;
    rstn = 1'b1;
    cyc(2);
    cnt = 9'h000;
    repeat (9) begin
      cyc(1);
      cnt = cnt + 9'(sys_clk);
    end
    check(cnt, 9'h003);
    for (int r = 0; r < 16; r++) begin
      {mode_dma, eight_chan, low_bank} = 3'(r);
      m = mode_dma ? (low_bank ? MASK_LOW : MASK_HIGH) : (eight_chan ? MASK_ALL : MASK_HIGH);
      cyc(4);
      round();
      for (int ch = 0; ch < NCH; ch++) begin
        pio_chan = 3'(ch);
        pio_branch = 1'b1;
        pio_xfer = 1'b1;
        cyc(1);
        check({1'b0, branch_cmd}, 9'(m & (8'h01 << ch)));
        check({1'b0, pio_sel}, 9'(m & (8'h01 << ch)));
      end
      {pio_branch, pio_xfer} = 2'h0;
      cyc(1);
      check({1'b0, branch_cmd | pio_sel}, 9'h000);
      if (mode_dma) begin
        diag();
        yield_case();
      end
    end
    summarize();
  end
endmodule // tb

`default_nettype wire
